// [src/sdram_cmd_pkg.sv]
package sdram_cmd_pkg;
   // Link geometry: the widest organisation sets the shared wire width
   localparam int LINK_W = 32;
   localparam int LINK_LANES = 4;
   localparam int ROW_W = 12;
   localparam int BANK_W = 2;
   localparam int BANKS = 4;
   localparam int OP_W = 11;
   localparam int AUTO_PRE_BIT = 10;
   localparam int COL_W16 = 9;
   localparam int COL_W32 = 8;
   localparam logic [BANK_W-1:0] SEL_BASE = 2'h0;
   localparam logic [BANK_W-1:0] SEL_EXT = 2'h2;
   // Read masks act two clocks after sampling, write masks at once
   localparam int READ_MASK_LAT = 2;
   localparam int CAPTURE_LAT = READ_MASK_LAT + 2;
   localparam logic [OP_W-1:0] MODE_RST = 11'h000;
   localparam logic [ROW_W-1:0] REFRESH_ROW_RST = 12'h000;
   localparam int MODE_LOAD_DELAY_CYC = 2;
   localparam int SELF_REF_STEP_CYC = 16;

   // Controller register map, one aligned word each
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_MASK = 8'h0c;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_BANK_LSB = 4;
   localparam int CMD_SELF_BIT = 8;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_SELF_BIT = 1;
   localparam int STAT_REFUSED_BIT = 2;
   localparam int STAT_OPEN_LSB = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      CMD_INHIBIT, CMD_NO_OP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
      CMD_BURST_STOP, CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_LOAD
   } cmd_e;

   // Pins are {select_n, row_n, col_n, write_n}
   function automatic cmd_e decode_cmd(input logic [3:0] pins);
      cmd_e c;
      c = CMD_INHIBIT;
      if (!pins[3]) begin
         case (pins[2:0])
            3'h7: c = CMD_NO_OP;
            3'h3: c = CMD_ACTIVATE;
            3'h5: c = CMD_READ;
            3'h4: c = CMD_WRITE;
            3'h6: c = CMD_BURST_STOP;
            3'h2: c = CMD_PRECHARGE;
            3'h1: c = CMD_REFRESH;
            default: c = CMD_MODE_LOAD;
         endcase
      end
      return c;
   endfunction

   function automatic logic [3:0] encode_cmd(input cmd_e c);
      logic [3:0] p;
      p = 4'h8;
      case (c)
         CMD_NO_OP: p = 4'h7;
         CMD_ACTIVATE: p = 4'h3;
         CMD_READ: p = 4'h5;
         CMD_WRITE: p = 4'h4;
         CMD_BURST_STOP: p = 4'h6;
         CMD_PRECHARGE: p = 4'h2;
         CMD_REFRESH: p = 4'h1;
         CMD_MODE_LOAD: p = 4'h0;
         default: p = 4'h8;
      endcase
      return p;
   endfunction
endpackage

// [src/sdram_controller.sv]
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module sdram_controller
   import sdram_cmd_pkg::*;
#(
   parameter int MODE_LOAD_DELAY = MODE_LOAD_DELAY_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   sdram_link_if.ctl link
);
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic aw_got_q, w_got_q;
   logic [7:0] waddr_q;
   logic [31:0] wdat_q;
   logic [3:0] wstrb_q;
   logic [ROW_W-1:0] addr_reg_q;
   logic [31:0] wdata_reg_q, rdata_reg_q;
   logic [LINK_LANES-1:0] mask_q;
   logic refused_q, cke_q, dq_oe_q;
   logic [3:0] pins_q;
   logic [BANK_W-1:0] ba_q;
   logic [ROW_W-1:0] addr_q;
   logic [31:0] dq_q;
   logic [BANKS-1:0] open_q;
   logic [CAPTURE_LAT-1:0] cap_sr_q;
   logic [7:0] mrd_q;

   logic do_wr, cmd_wr, busy, ok, issue;
   cmd_e op;
   logic [BANK_W-1:0] op_bank;
   logic [31:0] rd_mux;

   // Byte strobes pick which bytes of a register change
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   assign do_wr = aw_got_q && w_got_q && !bvalid_q;
   assign cmd_wr = do_wr && (waddr_q == REG_CMD);
   assign op = cmd_e'(wdat_q[CMD_OP_LSB +: 4]);
   assign op_bank = wdat_q[CMD_BANK_LSB +: BANK_W];
   // Busy while a read is in flight or the mode load delay runs
   assign busy = (cap_sr_q != '0) || (mrd_q != 8'h00);

   // Command check; refused commands never reach the pins
   always_comb begin
      ok = 1'b0;
      if (!busy) begin
         if (!cke_q) begin
            ok = (op == CMD_NO_OP);
         end else begin
            case (op)
               CMD_INHIBIT, CMD_NO_OP, CMD_BURST_STOP, CMD_PRECHARGE: ok = 1'b1;
               CMD_ACTIVATE: ok = !open_q[op_bank]; // R18
               CMD_READ, CMD_WRITE: ok = open_q[op_bank];
               CMD_REFRESH: ok = (open_q == '0);
               CMD_MODE_LOAD: ok = (open_q == '0) && (op_bank == SEL_BASE || op_bank == SEL_EXT); // R17 R10
               default: ok = 1'b0;
            endcase
         end
      end
   end
   assign issue = cmd_wr && ok;

   // Write channels: address and data taken in either order, response after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         waddr_q <= '0;
         wdat_q <= '0;
         wstrb_q <= '0;
      end else begin
         if (awvalid && awready_q) begin
            waddr_q <= awaddr;
            aw_got_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (wvalid && wready_q) begin
            wdat_q <= wdata;
            wstrb_q <= wstrb;
            w_got_q <= 1'b1;
            wready_q <= 1'b0;
         end
         if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= (waddr_q == REG_RDATA || waddr_q > REG_STATUS || waddr_q[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
         end
         if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // Software registers; a hardware refusal wins over a same-cycle clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_reg_q <= '0;
         wdata_reg_q <= '0;
         mask_q <= '0;
         refused_q <= 1'b0;
      end else begin
         if (do_wr && waddr_q == REG_ADDR) begin
            addr_reg_q <= ROW_W'(merge(32'(addr_reg_q), wdat_q, wstrb_q));
         end
         if (do_wr && waddr_q == REG_WDATA) begin
            wdata_reg_q <= merge(wdata_reg_q, wdat_q, wstrb_q);
         end
         if (do_wr && waddr_q == REG_MASK) begin
            mask_q <= LINK_LANES'(merge(32'(mask_q), wdat_q, wstrb_q));
         end
         if (cmd_wr && !ok) begin
            refused_q <= 1'b1;
         end else if (do_wr && waddr_q == REG_STATUS && wdat_q[STAT_REFUSED_BIT]) begin
            refused_q <= 1'b0;
         end
      end
   end

   // Pins: one cycle of the command, then no-op; gate low only in self refresh
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins_q <= encode_cmd(CMD_INHIBIT);
         cke_q <= 1'b1;
         ba_q <= '0;
         addr_q <= '0;
         dq_q <= '0;
         dq_oe_q <= 1'b0;
      end else begin
         pins_q <= issue ? encode_cmd(op) : encode_cmd(CMD_NO_OP); // R2 R3 R4 R5 R6 R7 R10
         dq_oe_q <= issue && (op == CMD_WRITE); // R5
         if (issue) begin
            ba_q <= op_bank;
            addr_q <= addr_reg_q;
            dq_q <= wdata_reg_q;
            if (op == CMD_REFRESH && wdat_q[CMD_SELF_BIT]) begin
               cke_q <= 1'b0; // R7 R9
            end else begin
               cke_q <= 1'b1; // R9
            end
         end
      end
   end

   // Bank shadow, read capture and mode load delay
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         open_q <= '0;
         cap_sr_q <= '0;
         mrd_q <= 8'h00;
         rdata_reg_q <= '0;
      end else begin
         cap_sr_q <= {cap_sr_q[CAPTURE_LAT-2:0], issue && (op == CMD_READ)};
         if (cap_sr_q[CAPTURE_LAT-1]) begin
            rdata_reg_q <= link.dq;
         end
         if (issue && op == CMD_MODE_LOAD) begin
            mrd_q <= 8'(MODE_LOAD_DELAY); // R17
         end else if (mrd_q != 8'h00) begin
            mrd_q <= mrd_q - 8'h01;
         end
         if (issue) begin
            case (op)
               CMD_ACTIVATE: open_q[op_bank] <= 1'b1; // R18
               CMD_READ, CMD_WRITE: begin
                  if (addr_reg_q[AUTO_PRE_BIT]) begin
                     open_q[op_bank] <= 1'b0;
                  end
               end
               CMD_PRECHARGE: begin
                  if (addr_reg_q[AUTO_PRE_BIT]) begin
                     open_q <= '0;
                  end else begin
                     open_q[op_bank] <= 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Read mux for the register map
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (araddr)
         REG_CMD: rd_mux = 32'h0000_0000;
         REG_ADDR: rd_mux = 32'(addr_reg_q);
         REG_WDATA: rd_mux = wdata_reg_q;
         REG_MASK: rd_mux = 32'(mask_q);
         REG_RDATA: rd_mux = rdata_reg_q;
         REG_STATUS: begin
            rd_mux[STAT_BUSY_BIT] = busy;
            rd_mux[STAT_SELF_BIT] = !cke_q;
            rd_mux[STAT_REFUSED_BIT] = refused_q;
            rd_mux[STAT_OPEN_LSB +: BANKS] = open_q;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Read channel: answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= (araddr > REG_STATUS || araddr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = pins_q;
   assign link.cke = cke_q;
   assign link.ba = ba_q;
   assign link.addr = addr_q;
   assign link.mask = mask_q;
   assign link.ctl_dq = dq_q;
   assign link.ctl_dq_oe = dq_oe_q;
endmodule

// [src/sdram_device.sv]
`timescale 1ns/1ps
// What the controller and this block do
// R1 - Select high: no new command accepted
// R2 - No-op does nothing new
// R3 - Activate decodes as select, row strobe low
// R4 - Read decodes and starts read
// R5 - Write decodes and stores valid data
// R6 - Precharge decodes with bank code
// R7 - Refresh: auto with gate high, self otherwise
// R8 - Refresh rows come from internal counter
// R9 - Controller keeps clock gate high normally
// R10 - Mode load picks base or extended register
// R11 - Activate takes row and bank
// R12 - Column per organisation; bit 10 auto precharge
// R13 - Precharge one bank or all banks
// R14 - Masks: writes immediate, reads two clocks
// R15 - Mask low enables lane, high blocks
// R16 - Each mask governs one byte lane
// R17 - Mode loads only when idle, then wait
// R18 - Row stays open until precharged
// R19 - Reserved mode select changes nothing
module sdram_device
   import sdram_cmd_pkg::*;
#(
   parameter int DATA_W = 16,
   parameter int MEM_ROW_W = 2,
   parameter int MEM_COL_W = 3,
   parameter int SELF_REF_STEP = SELF_REF_STEP_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   sdram_link_if.dev link,
   output logic [OP_W-1:0] base_mode,
   output logic [OP_W-1:0] ext_mode,
   output logic [BANKS-1:0] bank_open,
   output logic self_refresh,
   output logic [ROW_W-1:0] refresh_row,
   output logic [3:0] last_cmd,
   output logic ignored_cmd
);
   localparam int LANES = DATA_W / 8;
   localparam int COL_W = (DATA_W == 16) ? COL_W16 : COL_W32;
   localparam int MEM_AW = BANK_W + MEM_ROW_W + MEM_COL_W;

   logic [OP_W-1:0] base_q;
   logic [OP_W-1:0] ext_q;
   logic [BANKS-1:0] open_q;
   logic [ROW_W-1:0] row_q [BANKS];
   logic self_q;
   logic [ROW_W-1:0] ref_row_q;
   logic [15:0] step_q;
   logic [3:0] last_q;
   logic ignored_q;
   logic [LANES-1:0] oe_sr_q [READ_MASK_LAT+1];
   logic [DATA_W-1:0] data_sr_q [READ_MASK_LAT+1];

   cmd_e cmd;
   logic [BANK_W-1:0] bank;
   logic auto_pre;
   logic acc_ok;
   logic [COL_W-1:0] col;
   logic [MEM_AW-1:0] idx;
   logic [DATA_W-1:0] rd_word;

   // In self refresh the pins are not looked at, only the clock gate
   assign cmd = self_q ? CMD_INHIBIT : decode_cmd({link.cs_n, link.ras_n, link.cas_n, link.we_n}); // R1 R2 R3 R4 R5 R6
   assign bank = link.ba;
   assign auto_pre = link.addr[AUTO_PRE_BIT];
   assign col = link.addr[COL_W-1:0]; // R12
   // Only the open bank may be read or written
   assign acc_ok = open_q[bank];
   // The array keeps only a slice of row and column to stay small
   assign idx = {bank, row_q[bank][MEM_ROW_W-1:0], col[MEM_COL_W-1:0]};

   // Bank state: open rows persist until precharged
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         open_q <= '0;
         for (int b = 0; b < BANKS; b++) begin
            row_q[b] <= '0;
         end
      end else begin
         case (cmd)
            CMD_ACTIVATE: begin
               if (!open_q[bank]) begin // R18
                  open_q[bank] <= 1'b1; // R11
                  row_q[bank] <= link.addr; // R11
               end
            end
            CMD_READ, CMD_WRITE: begin
               if (acc_ok && auto_pre) begin
                  open_q[bank] <= 1'b0; // R12
               end
            end
            CMD_PRECHARGE: begin
               if (auto_pre) begin
                  open_q <= '0; // R13
               end else begin
                  open_q[bank] <= 1'b0; // R13
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Mode registers; reserved selects leave both untouched
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         base_q <= MODE_RST;
         ext_q <= MODE_RST;
      end else if (cmd == CMD_MODE_LOAD) begin
         if (bank == SEL_BASE) begin
            base_q <= link.addr[OP_W-1:0]; // R10
         end else if (bank == SEL_EXT) begin
            ext_q <= link.addr[OP_W-1:0]; // R10
         end // R19
      end
   end

   // Refresh: gate high steps the row counter, gate low enters self refresh
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         self_q <= 1'b0;
         ref_row_q <= REFRESH_ROW_RST;
         step_q <= '0;
      end else if (self_q) begin
         // The gate alone brings the device out; all else is ignored
         if (link.cke) begin
            self_q <= 1'b0;
            step_q <= '0;
         end else if (step_q == 16'(SELF_REF_STEP - 1)) begin
            step_q <= '0;
            ref_row_q <= ref_row_q + 1'b1; // R8
         end else begin
            step_q <= step_q + 1'b1;
         end
      end else if (cmd == CMD_REFRESH) begin
         if (link.cke) begin
            ref_row_q <= ref_row_q + 1'b1; // R7 R8
         end else begin
            self_q <= 1'b1; // R7 R9
         end
      end
   end

   // Command trace and a pulse for commands that had no effect
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_q <= 4'(CMD_INHIBIT);
         ignored_q <= 1'b0;
      end else begin
         if (cmd != CMD_INHIBIT && cmd != CMD_NO_OP) begin
            last_q <= 4'(cmd);
         end
         case (cmd)
            CMD_ACTIVATE: ignored_q <= open_q[bank];
            CMD_READ, CMD_WRITE: ignored_q <= !acc_ok;
            CMD_MODE_LOAD: ignored_q <= (bank != SEL_BASE) && (bank != SEL_EXT); // R19
            default: ignored_q <= 1'b0;
         endcase
      end
   end

   // Per lane storage; a high mask blocks the write in the same clock
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         logic [7:0] lane_mem [2**MEM_AW];
         always_ff @(posedge aclk) begin
            if (cmd == CMD_WRITE && acc_ok && !link.mask[g]) begin // R14 R15 R16
               lane_mem[idx] <= link.dq[g*8 +: 8]; // R5
            end
         end
         assign rd_word[g*8 +: 8] = lane_mem[idx];
      end
   endgenerate

   // Read pipe: mask sampled with the command sets the lane enables two clocks on
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i <= READ_MASK_LAT; i++) begin
            oe_sr_q[i] <= '0;
            data_sr_q[i] <= '0;
         end
      end else begin
         oe_sr_q[0] <= (cmd == CMD_READ && acc_ok) ? ~link.mask[LANES-1:0] : '0; // R4 R14 R15 R16
         data_sr_q[0] <= rd_word;
         for (int i = 1; i <= READ_MASK_LAT; i++) begin
            oe_sr_q[i] <= oe_sr_q[i-1];
            data_sr_q[i] <= data_sr_q[i-1];
         end
      end
   end

   assign link.dev_dq = LINK_W'(data_sr_q[READ_MASK_LAT]);
   assign link.dev_dq_oe = LINK_LANES'(oe_sr_q[READ_MASK_LAT]);

   // Status outputs, all straight from registers
   assign base_mode = base_q;
   assign ext_mode = ext_q;
   assign bank_open = open_q;
   assign self_refresh = self_q;
   assign refresh_row = ref_row_q;
   assign last_cmd = last_q;
   assign ignored_cmd = ignored_q;
endmodule

// [src/sdram_link_if.sv]
`timescale 1ns/1ps
interface sdram_link_if;
   import sdram_cmd_pkg::*;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic cke;
   logic [BANK_W-1:0] ba;
   logic [ROW_W-1:0] addr;
   logic [LINK_LANES-1:0] mask;
   logic [LINK_W-1:0] ctl_dq;
   logic ctl_dq_oe;
   logic [LINK_W-1:0] dev_dq;
   logic [LINK_LANES-1:0] dev_dq_oe;
   logic [LINK_W-1:0] dq;

   // Shared data wire; an undriven lane reads as zero
   genvar g;
   generate
      for (g = 0; g < LINK_LANES; g++) begin : g_lane
         assign dq[g*8 +: 8] = ctl_dq_oe ? ctl_dq[g*8 +: 8] : (dev_dq_oe[g] ? dev_dq[g*8 +: 8] : 8'h00);
      end
   endgenerate

   modport ctl (output cs_n, ras_n, cas_n, we_n, cke, ba, addr, mask, ctl_dq, ctl_dq_oe, input dq);
   modport dev (input cs_n, ras_n, cas_n, we_n, cke, ba, addr, mask, dq, output dev_dq, dev_dq_oe);
endinterface

// [verif/sdram_command_decoder_test.sv]
`timescale 1ns/1ps
module sdram_command_decoder_test;
   import sdram_cmd_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic wvalid = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, self_refresh, ignored_cmd;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [OP_W-1:0] base_mode, ext_mode;
   logic [BANKS-1:0] bank_open;
   logic [ROW_W-1:0] refresh_row;
   logic [3:0] last_cmd;
   logic [31:0] d;
   logic [1:0] r;
   int fails = 0;
   int samples_checked = 0;
   logic ign_seen = 1'b0;

   sdram_link_if link();
   // Ready lines held high: the master may always accept answers
   sdram_controller i_sdram_controller (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .link(link.ctl));
   // Wide organisation so all four lanes are exercised; short self refresh step
   sdram_device #(.DATA_W(32), .SELF_REF_STEP(4)) i_sdram_device (.aclk(aclk), .aresetn(aresetn),
      .link(link.dev), .base_mode(base_mode), .ext_mode(ext_mode), .bank_open(bank_open),
      .self_refresh(self_refresh), .refresh_row(refresh_row), .last_cmd(last_cmd), .ignored_cmd(ignored_cmd));
   sdram_link_asserts i_sdram_link_asserts (.aclk(aclk), .aresetn(aresetn), .cs_n(link.cs_n),
      .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .cke(link.cke), .mask(link.mask),
      .ctl_dq_oe(link.ctl_dq_oe), .dev_dq_oe(link.dev_dq_oe));

   initial begin
      forever #12.5 aclk = ~aclk;
   end

   // The controller must never pass a command that the device throws away
   always @(posedge aclk) begin
      if (aresetn && ignored_cmd !== 1'b0) begin
         ign_seen <= 1'b1;
      end
   end

   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task hang(input string what);
      fails++;
      $display("unexpected at %0t: %s timed out", $time, what);
      stop_test();
   endtask

   // Address and data offered together, each released once taken
   task axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      logic done;
      done = 1'b0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            done = 1'b1;
            chk({30'h0, bresp}, {30'h0, er}, "bresp");
         end
      end
      if (!done) hang("write");
   endtask

   task axi_rd(input logic [7:0] a);
      logic done;
      done = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            done = 1'b1;
            d = rdata;
            r = rresp;
         end
      end
      if (!done) hang("read");
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
      axi_rd(a);
      chk(d, exp, what);
      chk({30'h0, r}, {30'h0, er}, "rresp");
   endtask

   // Busy covers read capture and mode load delay; polled, never assumed
   task issue(input logic [3:0] code, input logic [1:0] bank, input logic [11:0] a);
      logic done;
      done = 1'b0;
      axi_wr(REG_ADDR, {20'h0, a}, RESP_OKAY);
      axi_wr(REG_CMD, {26'h0, bank, code}, RESP_OKAY);
      for (int n = 0; n < 20 && !done; n++) begin
         axi_rd(REG_STATUS);
         done = (d[STAT_BUSY_BIT] === 1'b0);
      end
      if (!done) hang("busy");
   endtask

   // Open banks and sticky refusal; refusal cleared after each look that expects it
   task st(input logic [3:0] open, input logic refd);
      rd_chk(REG_STATUS, {24'h0, open, 1'b0, refd, 2'h0}, RESP_OKAY, "status");
      chk({28'h0, bank_open}, {28'h0, open}, "device banks");
      if (refd) axi_wr(REG_STATUS, 32'h4, RESP_OKAY);
   endtask

   task t_regs;
      rd_chk(REG_STATUS, 32'h0, RESP_OKAY, "status after reset");
      axi_wr(8'h18, 32'h1, RESP_SLVERR);
      axi_wr(REG_RDATA, 32'h1, RESP_SLVERR);
      rd_chk(8'h18, 32'h0, RESP_SLVERR, "unmapped read");
   endtask

   task t_data;
      issue(4'h2, 2'h1, 12'h005);
      st(4'h2, 1'b0);
      axi_wr(REG_WDATA, 32'h11111111, RESP_OKAY);
      issue(4'h4, 2'h1, 12'h003);
      axi_wr(REG_WDATA, 32'ha1b2c3d4, RESP_OKAY);
      axi_wr(REG_MASK, 32'h2, RESP_OKAY);
      issue(4'h4, 2'h1, 12'h003);
      axi_wr(REG_MASK, 32'h8, RESP_OKAY);
      issue(4'h3, 2'h1, 12'h003);
      rd_chk(REG_RDATA, 32'h00b211d4, RESP_OKAY, "masked read");
      axi_wr(REG_MASK, 32'h0, RESP_OKAY);
      issue(4'h3, 2'h1, 12'h403);
      rd_chk(REG_RDATA, 32'ha1b211d4, RESP_OKAY, "full read");
      st(4'h0, 1'b0);
      issue(4'h3, 2'h1, 12'h003);
      st(4'h0, 1'b1);
   endtask

   task t_banks;
      issue(4'h2, 2'h0, 12'h000);
      issue(4'h2, 2'h2, 12'h000);
      issue(4'h2, 2'h0, 12'h001);
      st(4'h5, 1'b1);
      issue(4'h6, 2'h0, 12'h000);
      st(4'h4, 1'b0);
      issue(4'h2, 2'h0, 12'h000);
      issue(4'h6, 2'h1, 12'h400);
      st(4'h0, 1'b0);
   endtask

   task t_mode;
      issue(4'h8, SEL_BASE, 12'h123);
      chk({21'h0, base_mode}, 32'h123, "base mode");
      issue(4'h8, SEL_EXT, 12'h0a5);
      chk({21'h0, ext_mode}, 32'h0a5, "ext mode");
      issue(4'h8, 2'h1, 12'h7ff);
      st(4'h0, 1'b1);
      chk({10'h0, base_mode, ext_mode}, {10'h0, 11'h123, 11'h0a5}, "modes kept");
      issue(4'h7, 2'h0, 12'hfff);
      chk({28'h0, last_cmd}, 32'h7, "auto refresh");
      chk({20'h0, refresh_row}, 32'h1, "refresh row step");
      issue(4'h0, 2'h0, 12'h000);
      chk({28'h0, last_cmd}, 32'h7, "inhibit");
      axi_wr(REG_CMD, 32'h107, RESP_OKAY);
      axi_rd(REG_STATUS);
      chk({31'h0, d[STAT_SELF_BIT]}, 32'h1, "self status");
      chk({31'h0, self_refresh}, 32'h1, "self entry");
      issue(4'h1, 2'h0, 12'h000);
      chk({31'h0, self_refresh}, 32'h0, "self exit");
      chk({31'h0, refresh_row > 12'h001}, 32'h1, "self refresh rows");
      chk({28'h0, last_cmd}, 32'h7, "no-op");
   endtask

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_data();
      t_banks();
      t_mode();
      chk({31'h0, ign_seen}, 32'h0, "commands ignored by device");
      stop_test();
   end
endmodule

// [verif/sdram_link_asserts.sv]
`timescale 1ns/1ps
module sdram_link_asserts
   import sdram_cmd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic cke,
   input wire logic [LINK_LANES-1:0] mask,
   input wire logic ctl_dq_oe,
   input wire logic [LINK_LANES-1:0] dev_dq_oe
);
   // Decoded pin groups shared by the properties
   wire [3:0] pins = {cs_n, ras_n, cas_n, we_n};
   wire rd = (pins == 4'h5);
   wire wr = (pins == 4'h4);
   wire ml = (pins == 4'h0);
   wire rf = (pins == 4'h1);
   wire idle = cs_n | (pins == 4'h7);

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_READ_LANES: assert property (rd |-> ##3 (dev_dq_oe == ~$past(mask, 3)))
      else $error("read lane drive does not follow mask");
   AST_DRIVE_CAUSE: assert property ((dev_dq_oe != 4'h0) |-> $past(rd, 3))
      else $error("device drives data without a read");
   AST_WRITE_DATA: assert property (ctl_dq_oe == wr)
      else $error("write data drive not aligned with write");
   AST_NO_CLASH: assert property (ctl_dq_oe |-> (dev_dq_oe == 4'h0))
      else $error("both ends drive data");
   AST_CMD_SHORT: assert property (!idle |=> idle)
      else $error("command held beyond one cycle");
   AST_MODE_WAIT: assert property (ml |=> idle [*2])
      else $error("command too soon after mode load");
   AST_SELF_ENTRY: assert property ($fell(cke) |-> rf)
      else $error("clock gate dropped without refresh");
   AST_GATE_LOW_NOP: assert property ((!cke && !$fell(cke)) |-> (pins == 4'h7))
      else $error("command issued while clock gate low");

   // Main traffic kinds are seen at least once
   cover property (rd);
   cover property (wr);
   cover property (ml);
   cover property ($fell(cke));
endmodule
